// ### hw/pdts_top.sv
// Dead-time edge select register with its AXI4-Lite slave and the pairs.
// Assumes the dead-time unit counts and PWM signals come from neighbouring
// blocks in the same clock domain, and that a second instance of the PWM
// module is built with ACTIVE_PAIRS set to one.
//
// The register addresses and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps

module pdts_top #(
  parameter int unsigned NUM_PAIRS    = 3,
  parameter int unsigned ACTIVE_PAIRS = 3,
  parameter int unsigned CNT_W        = 6
) (
  // Clock and reset.
  input  wire logic                 clk_i,
  input  wire logic                 rst_n_i,
  // AXI4-Lite write address channel.
  input  wire logic                 s_axi_awvalid_i,
  output logic                      s_axi_awready_o,
  input  wire logic [31:0]          s_axi_awaddr_i,
  input  wire logic [2:0]           s_axi_awprot_i,
  // AXI4-Lite write data channel.
  input  wire logic                 s_axi_wvalid_i,
  output logic                      s_axi_wready_o,
  input  wire logic [31:0]          s_axi_wdata_i,
  input  wire logic [3:0]           s_axi_wstrb_i,
  // AXI4-Lite write response channel.
  output logic                      s_axi_bvalid_o,
  input  wire logic                 s_axi_bready_i,
  output logic [1:0]                s_axi_bresp_o,
  // AXI4-Lite read address channel.
  input  wire logic                 s_axi_arvalid_i,
  output logic                      s_axi_arready_o,
  input  wire logic [31:0]          s_axi_araddr_i,
  input  wire logic [2:0]           s_axi_arprot_i,
  // AXI4-Lite read data channel.
  output logic                      s_axi_rvalid_o,
  input  wire logic                 s_axi_rready_i,
  output logic [31:0]               s_axi_rdata_o,
  output logic [1:0]                s_axi_rresp_o,
  // Dead-time unit counts from the unit value logic.
  input  wire logic [CNT_W-1:0]     dt_unit_a_cnt_i,
  input  wire logic [CNT_W-1:0]     dt_unit_b_cnt_i,
  // Underlying PWM signals, one per pair.
  input  wire logic [NUM_PAIRS-1:0] pwm_i,
  // Complementary outputs towards the drivers.
  output logic [NUM_PAIRS-1:0]      pwm_hi_o,
  output logic [NUM_PAIRS-1:0]      pwm_lo_o
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------

  // Write path state.
  logic                               aw_full_reg;
  logic                               aw_full_next;
  logic                               w_full_reg;
  logic                               w_full_next;
  logic [pdts_pkg::ADDR_W-1:0]        waddr_reg;
  logic [pdts_pkg::ADDR_W-1:0]        waddr_next;
  logic [31:0]                        wdata_reg;
  logic [31:0]                        wdata_next;
  logic [3:0]                         wstrb_reg;
  logic [3:0]                         wstrb_next;
  logic                               awready_reg;
  logic                               awready_next;
  logic                               wready_reg;
  logic                               wready_next;
  logic                               bvalid_reg;
  logic                               bvalid_next;
  logic [1:0]                         bresp_reg;
  logic [1:0]                         bresp_next;
  logic                               aw_take;
  logic                               w_take;
  logic                               do_write;
  logic                               wmapped;

  // Read path state.
  logic                               arready_reg;
  logic                               arready_next;
  logic                               rvalid_reg;
  logic                               rvalid_next;
  logic [31:0]                        rdata_reg;
  logic [31:0]                        rdata_next;
  logic [1:0]                         rresp_reg;
  logic [1:0]                         rresp_next;
  logic                               ar_take;
  logic [pdts_pkg::ADDR_W-1:0]        raddr;
  logic [31:0]                        rword;
  logic                               rmapped;

  // Select register and pair outputs.
  logic [pdts_pkg::EDGE_SEL_W-1:0]    edge_sel_reg;
  logic [pdts_pkg::EDGE_SEL_W-1:0]    edge_sel_next;
  logic [NUM_PAIRS-1:0]               pair_hi;
  logic [NUM_PAIRS-1:0]               pair_lo;

  // ----------------------------------------------------------------------
  // Write channels
  // ----------------------------------------------------------------------

  // Address and data are caught in either order; the register is written
  // once both are held and no response is still waiting.
  always_comb begin
    aw_take      = s_axi_awvalid_i & awready_reg;
    w_take       = s_axi_wvalid_i & wready_reg;
    do_write     = aw_full_reg & w_full_reg & ~bvalid_reg;
    wmapped      = (waddr_reg == pdts_pkg::EDGE_SEL_OFFSET) ||
                   (waddr_reg == pdts_pkg::STATUS_OFFSET);
    aw_full_next = aw_full_reg;
    w_full_next  = w_full_reg;
    waddr_next   = waddr_reg;
    wdata_next   = wdata_reg;
    wstrb_next   = wstrb_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    if (aw_take) begin
      aw_full_next = 1'b1;
      waddr_next   = {s_axi_awaddr_i[pdts_pkg::ADDR_W-1:2], 2'h0};
    end
    if (w_take) begin
      w_full_next  = 1'b1;
      wdata_next   = s_axi_wdata_i;
      wstrb_next   = s_axi_wstrb_i;
    end
    if (bvalid_reg && s_axi_bready_i) begin
      bvalid_next  = 1'b0;
    end
    if (do_write) begin
      aw_full_next = 1'b0;
      w_full_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = wmapped ? pdts_pkg::RESP_OKAY : pdts_pkg::RESP_SLVERR;
    end
    awready_next = ~aw_full_next & ~bvalid_next;
    wready_next  = ~w_full_next & ~bvalid_next;
  end

  // Write channel registers.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      waddr_reg   <= '0;
      wdata_reg   <= 32'h0000_0000;
      wstrb_reg   <= 4'h0;
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= pdts_pkg::RESP_OKAY;
    end else begin
      aw_full_reg <= aw_full_next;
      w_full_reg  <= w_full_next;
      waddr_reg   <= waddr_next;
      wdata_reg   <= wdata_next;
      wstrb_reg   <= wstrb_next;
      awready_reg <= awready_next;
      wready_reg  <= wready_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
    end
  end

  // ----------------------------------------------------------------------
  // Select register
  // ----------------------------------------------------------------------

  // Only the low byte holds implemented bits; the upper bits of the word
  // are dropped, and the status word takes no write.
  always_comb begin
    edge_sel_next = edge_sel_reg;
    if (do_write && (waddr_reg == pdts_pkg::EDGE_SEL_OFFSET) &&
        wstrb_reg[0]) begin
      edge_sel_next = wdata_reg[pdts_pkg::EDGE_SEL_W-1:0]; // [R01]
    end
  end

  // Select register storage.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      edge_sel_reg <= pdts_pkg::EDGE_SEL_RESET;
    end else begin
      edge_sel_reg <= edge_sel_next;
    end
  end

  // ----------------------------------------------------------------------
  // Read channels
  // ----------------------------------------------------------------------

  // Read word for the decoded address; unused bits are zero.
  always_comb begin
    raddr   = {s_axi_araddr_i[pdts_pkg::ADDR_W-1:2], 2'h0};
    rword   = 32'h0000_0000;
    rmapped = 1'b1;
    if (raddr == pdts_pkg::EDGE_SEL_OFFSET) begin
      rword[pdts_pkg::EDGE_SEL_W-1:0] = edge_sel_reg; // [R01]
    end else if (raddr == pdts_pkg::STATUS_OFFSET) begin
      rword[pdts_pkg::STATUS_HI_POS +: NUM_PAIRS] = pair_hi;
      rword[pdts_pkg::STATUS_LO_POS +: NUM_PAIRS] = pair_lo;
    end else begin
      rmapped = 1'b0;
    end
  end

  // One read at a time: the address is taken, the data follow a cycle
  // later and stand until the master accepts them.
  always_comb begin
    ar_take     = s_axi_arvalid_i & arready_reg;
    rvalid_next = rvalid_reg;
    rdata_next  = rdata_reg;
    rresp_next  = rresp_reg;
    if (rvalid_reg && s_axi_rready_i) begin
      rvalid_next = 1'b0;
    end
    if (ar_take) begin
      rvalid_next = 1'b1;
      rdata_next  = rword;
      rresp_next  = rmapped ? pdts_pkg::RESP_OKAY : pdts_pkg::RESP_SLVERR;
    end
    arready_next = ~rvalid_next & ~ar_take;
  end

  // Read channel registers.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= pdts_pkg::RESP_OKAY;
    end else begin
      arready_reg <= arready_next;
      rvalid_reg  <= rvalid_next;
      rdata_reg   <= rdata_next;
      rresp_reg   <= rresp_next;
    end
  end

  // Bus outputs come straight from their registers.
  assign s_axi_awready_o = awready_reg;
  assign s_axi_wready_o  = wready_reg;
  assign s_axi_bvalid_o  = bvalid_reg;
  assign s_axi_bresp_o   = bresp_reg;
  assign s_axi_arready_o = arready_reg;
  assign s_axi_rvalid_o  = rvalid_reg;
  assign s_axi_rdata_o   = rdata_reg;
  assign s_axi_rresp_o   = rresp_reg;

  // ----------------------------------------------------------------------
  // Output pairs
  // ----------------------------------------------------------------------

  // Pair i reads select bits 2i+1 for its active edge and 2i for its
  // inactive edge; pairs past ACTIVE_PAIRS stay off whatever is written.
  for (genvar i = 0; i < NUM_PAIRS; i++) begin : g_pair
    pdts_pair #(
      .CNT_W          (CNT_W)
    ) u_pair (
      .clk_i          (clk_i),
      .rst_n_i        (rst_n_i),
      .enable_i       (i < ACTIVE_PAIRS), // [R07]
      .pwm_i          (pwm_i[i]),
      // Bits 5, 3 and 1 for pairs three, two and one. [R03] [R05] [R06]
      .sel_active_i   (edge_sel_reg[i*pdts_pkg::BITS_PER_PAIR +
                                    pdts_pkg::ACTIVE_POS]),
      // Bits 4, 2 and 0 for pairs three, two and one. [R04] [R05] [R06]
      .sel_inactive_i (edge_sel_reg[i*pdts_pkg::BITS_PER_PAIR +
                                    pdts_pkg::INACTIVE_POS]),
      .cnt_a_i        (dt_unit_a_cnt_i),
      .cnt_b_i        (dt_unit_b_cnt_i),
      .hi_o           (pair_hi[i]),
      .lo_o           (pair_lo[i])
    );
  end

  // Pair outputs are flops inside each pair.
  assign pwm_hi_o = pair_hi;
  assign pwm_lo_o = pair_lo;

endmodule : pdts_top

// ### hw/pdts_pkg.sv
// Constants shared by the dead-time edge select block and its pair logic.
// Assumes a 32-bit AXI4-Lite register bus and one clock for all logic.
//
// Function
// R01: Bits 15 to 6 of the select register read zero and ignore writes.
// R02: A select bit at one picks unit B, at zero unit A.
// R03: Bit 5 picks the unit for the third pair going active.
// R04: Bit 4 picks the unit for the third pair going inactive.
// R05: Bits 3 and 2 pick units for second pair active and inactive edges.
// R06: Bits 1 and 0 pick units for first pair active and inactive edges.
// R07: The second module instance has one pair; only pair one bits act.
// R08: Each edge delays the turning-on output by the selected unit's count.

package pdts_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------

  // Byte offsets of the registers on the bus.
  localparam logic [11:0] EDGE_SEL_OFFSET = 12'h000;
  localparam logic [11:0] STATUS_OFFSET   = 12'h004;
  // Address bits that take part in the decode.
  localparam int unsigned ADDR_W          = 12;

  // Width of the select register as software sees it.
  localparam int unsigned EDGE_SEL_REG_W  = 16;
  // Number of implemented select bits, bits 5 down to 0.
  localparam int unsigned EDGE_SEL_W      = 6;
  // Value of the select bits after reset.
  localparam logic [5:0]  EDGE_SEL_RESET  = 6'h00;

  // ----------------------------------------------------------------------
  // Field layout of the select register
  // ----------------------------------------------------------------------

  // Each pair owns two neighbouring bits: inactive edge low, active high.
  localparam int unsigned BITS_PER_PAIR   = 2;
  localparam int unsigned INACTIVE_POS    = 0;
  localparam int unsigned ACTIVE_POS      = 1;

  // Encoding of one select bit.
  localparam logic        UNIT_A          = 1'b0;
  localparam logic        UNIT_B          = 1'b1;

  // Status register: high side outputs at bit 0 up, low side at bit 4 up.
  localparam int unsigned STATUS_HI_POS   = 0;
  localparam int unsigned STATUS_LO_POS   = 4;

  // ----------------------------------------------------------------------
  // Bus answers
  // ----------------------------------------------------------------------

  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

endpackage : pdts_pkg

// ### hw/pdts_pair.sv
// One complementary output pair with dead-time insertion on both edges.
// Assumes the PWM input and the unit counts are synchronous to clk_i.
`timescale 1ns/1ps

module pdts_pair #(
  parameter int unsigned CNT_W = 6
) (
  // Clock and reset.
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  // Pair enable, low for pairs that the instance lacks.
  input  wire logic             enable_i,
  // Underlying PWM signal of the pair.
  input  wire logic             pwm_i,
  // Unit choice per edge, one meaning unit B.
  input  wire logic             sel_active_i,
  input  wire logic             sel_inactive_i,
  // Dead-time counts of the two units.
  input  wire logic [CNT_W-1:0] cnt_a_i,
  input  wire logic [CNT_W-1:0] cnt_b_i,
  // Complementary outputs.
  output logic                  hi_o,
  output logic                  lo_o
);

  logic             pwm_d_reg;
  logic             pwm_d_next;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic             hi_reg;
  logic             hi_next;
  logic             lo_reg;
  logic             lo_next;
  logic             edge_seen;
  logic             edge_sel;

  // An edge blanks both outputs, then the side that turns on waits out
  // the count of the unit chosen for that edge direction.
  always_comb begin
    edge_seen  = pwm_i != pwm_d_reg;
    edge_sel   = pwm_i ? sel_active_i : sel_inactive_i;
    pwm_d_next = pwm_i;
    cnt_next   = cnt_reg;
    hi_next    = hi_reg;
    lo_next    = lo_reg;
    if (!enable_i) begin
      cnt_next = '0;
      hi_next  = 1'b0;
      lo_next  = 1'b0;
    end else if (edge_seen) begin
      cnt_next = (edge_sel == pdts_pkg::UNIT_B) ? cnt_b_i : cnt_a_i; // [R02]
      hi_next  = 1'b0; // [R08]
      lo_next  = 1'b0; // [R08]
    end else if (cnt_reg != '0) begin
      cnt_next = cnt_reg - 1'b1; // [R08]
      hi_next  = 1'b0;
      lo_next  = 1'b0;
    end else begin
      hi_next  = pwm_d_reg;
      lo_next  = ~pwm_d_reg;
    end
  end

  // State registers of the pair.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pwm_d_reg <= 1'b0;
      cnt_reg   <= '0;
      hi_reg    <= 1'b0;
      lo_reg    <= 1'b0;
    end else begin
      pwm_d_reg <= pwm_d_next;
      cnt_reg   <= cnt_next;
      hi_reg    <= hi_next;
      lo_reg    <= lo_next;
    end
  end

  assign hi_o = hi_reg;
  assign lo_o = lo_reg;

endmodule : pdts_pair

// ### tb/pdts_top_asserts.sv
// Checker for the dead-time edge select block, bound to its top module.
// Assumes one clock domain and sees only the top module's ports.
`timescale 1ns/1ps

module pdts_top_asserts #(
  parameter int unsigned NUM_PAIRS    = 3,
  parameter int unsigned ACTIVE_PAIRS = 3,
  parameter int unsigned CNT_W        = 6
) (
  // Clock and reset.
  input wire logic                 clk_i,
  input wire logic                 rst_n_i,
  // Register bus handshakes.
  input wire logic                 s_axi_awvalid_i,
  input wire logic                 s_axi_awready_o,
  input wire logic                 s_axi_wvalid_i,
  input wire logic                 s_axi_wready_o,
  input wire logic                 s_axi_bvalid_o,
  input wire logic                 s_axi_bready_i,
  input wire logic [1:0]           s_axi_bresp_o,
  input wire logic                 s_axi_arvalid_i,
  input wire logic                 s_axi_arready_o,
  input wire logic [31:0]          s_axi_araddr_i,
  input wire logic                 s_axi_rvalid_o,
  input wire logic [31:0]          s_axi_rdata_o,
  // Dead-time counts and pairs.
  input wire logic [CNT_W-1:0]     dt_unit_a_cnt_i,
  input wire logic [CNT_W-1:0]     dt_unit_b_cnt_i,
  input wire logic [NUM_PAIRS-1:0] pwm_i,
  input wire logic [NUM_PAIRS-1:0] pwm_hi_o,
  input wire logic [NUM_PAIRS-1:0] pwm_lo_o
);
  logic rd_sel_reg;
  logic rd_sel_next;

  // Remembers whether the read under way targets the select register.
  always_comb begin
    rd_sel_next = rd_sel_reg;
    if (s_axi_arvalid_i && s_axi_arready_o) begin
      rd_sel_next = (s_axi_araddr_i[11:2] == 10'h000);
    end
  end
  always_ff @(posedge clk_i) begin
    rd_sel_reg <= rst_n_i ? rd_sel_next : 1'b0;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // Bus requests taken at one edge.
  sequence s_wr_both;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid_i && s_axi_arready_o;
  endsequence

  a_never_both_on:
    assert property ((pwm_hi_o & pwm_lo_o) == '0)
      else $error("both outputs of a pair on");
  a_turn_off_fast:
    assert property ($changed(pwm_i[0]) |=> !pwm_hi_o[0] && !pwm_lo_o[0])
      else $error("pair output still on after its edge");
  a_zero_dead_time:
    assert property ($rose(pwm_i[0]) && dt_unit_a_cnt_i == '0 &&
      dt_unit_b_cnt_i == '0 ##1 pwm_i[0] |=> pwm_hi_o[0])
      else $error("high side late with zero dead time");
  a_hi_needs_high:
    assert property ((pwm_hi_o & ~$past(pwm_hi_o) & ~$past(pwm_i)) == '0)
      else $error("high side rose while pwm low");
  a_lo_needs_low:
    assert property ((pwm_lo_o & ~$past(pwm_lo_o) & $past(pwm_i)) == '0)
      else $error("low side rose while pwm high");
  a_unbuilt_pairs:
    assert property (((pwm_hi_o | pwm_lo_o) >> ACTIVE_PAIRS) == '0)
      else $error("missing pair drives an output");
  a_sel_read_zero:
    assert property (s_axi_rvalid_o && rd_sel_reg |->
      s_axi_rdata_o[31:6] == '0) else $error("upper select bits not zero");
  a_read_answer:
    assert property (s_rd_take |=> s_axi_rvalid_o)
      else $error("read answer late");
  a_write_answer:
    assert property (s_wr_both |-> ##2 s_axi_bvalid_o)
      else $error("write answer late");
  a_resp_holds:
    assert property (s_axi_bvalid_o && !s_axi_bready_i |=>
      s_axi_bvalid_o && $stable(s_axi_bresp_o)) else $error("bresp dropped");
endmodule : pdts_top_asserts

// ### tb/pdts_top_tb.sv
// Self-checking bench for the dead-time edge select block.
// Assumes the checker file is compiled first; a one-pair copy runs beside.
`timescale 1ns/1ps

module pdts_top_tb;
  logic        clk_i, rst_n_i, chk_en;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [5:0]  dta, dtb, msel, s;
  logic [2:0]  pwm, hi, lo, hi2, lo2, last, tgt, mh, ml;
  int          cnt [3];
  int          bad_count, comparisons, k;

  // Full block and a copy built with one pair, fed the same inputs.
  pdts_top uut (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_awaddr_i(awaddr), .s_axi_awprot_i(3'h0),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_bresp_o(bresp),
    .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_araddr_i(araddr), .s_axi_arprot_i(3'h0),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .dt_unit_a_cnt_i(dta), .dt_unit_b_cnt_i(dtb), .pwm_i(pwm),
    .pwm_hi_o(hi), .pwm_lo_o(lo));
  pdts_top #(.ACTIVE_PAIRS(1)) uut2 (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(), .s_axi_awaddr_i(awaddr),
    .s_axi_awprot_i(3'h0), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_bvalid_o(),
    .s_axi_bready_i(bready), .s_axi_bresp_o(), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(), .s_axi_araddr_i(araddr), .s_axi_arprot_i(3'h0),
    .s_axi_rvalid_o(), .s_axi_rready_i(rready), .s_axi_rdata_o(),
    .s_axi_rresp_o(), .dt_unit_a_cnt_i(dta), .dt_unit_b_cnt_i(dtb),
    .pwm_i(pwm), .pwm_hi_o(hi2), .pwm_lo_o(lo2));

  // Clock of 100 ns period.
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // Compares a bus value and counts the comparison.
  task automatic chk_bus(input string nm, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_bus

  // Compares the pair outputs as {low sides, high sides}.
  task automatic chk_out(input string nm, input logic [5:0] e, g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_out

  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict;
    $display("Mismatches %0d in %0d comparisons", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : give_verdict

  // Ends the run when a bus answer never came.
  task automatic hang(input int n);
    if (n >= 60) begin
      bad_count++;
      $display("ERROR bus answer expected 1 seen 0");
      give_verdict();
    end
  endtask : hang

  // One write; address and data released each when taken.
  task automatic axi_write(input logic [31:0] a, d, input logic [3:0] st,
                           input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk_i);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= st;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      // Ready follows the answer by a cycle, so the answer must stand.
      if (bvalid === 1'b1 && bready !== 1'b1) bready <= 1'b1;
    end while (!(bvalid === 1'b1 && bready === 1'b1) && n < 60);
    bready <= 1'b0;
    hang(n);
    chk_bus("write response", {30'h0, er}, {30'h0, bresp});
  endtask : axi_write

  // One read; data and response taken at the answer edge.
  task automatic axi_read(input logic [31:0] a, e, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk_i);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 60);
    rready <= 1'b0;
    hang(n);
    chk_bus("read data", e, rdata);
    chk_bus("read response", {30'h0, er}, {30'h0, rresp});
  endtask : axi_read

  // Pair model: checked against both copies, then advanced one edge.
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      {mh, ml, last, tgt} = '0;
      cnt = '{0, 0, 0};
    end else begin
      if (chk_en) begin
        chk_out("pair outputs", {ml, mh}, {lo, hi});
        chk_out("copy", {2'h0, ml[0], 2'h0, mh[0]}, {lo2, hi2});
      end
      for (int p = 0; p < 3; p++) begin
        if (pwm[p] !== last[p]) begin
          cnt[p] = msel[2*p+pwm[p]] ? int'(dtb) : int'(dta);
          mh[p] = 1'b0;
          ml[p] = 1'b0;
          tgt[p] = pwm[p];
        end else if (cnt[p] > 0) begin
          cnt[p]--;
        end else begin
          mh[p] = tgt[p];
          ml[p] = ~tgt[p];
        end
        last[p] = pwm[p];
      end
    end
  end

  // Main sequence.
  initial begin
    k = $urandom(32'h12e7);
    {awvalid, wvalid, bready, arvalid, rready, chk_en} = '0;
    {awaddr, wdata, araddr} = '0;
    {wstrb, dta, dtb, msel, pwm} = '0;
    bad_count = 0;
    comparisons = 0;
    rst_n_i = 1'b0;
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    chk_en <= 1'b1;
    axi_read(32'h0, 32'h0, pdts_pkg::RESP_OKAY);
    axi_write(32'h0, 32'hffff_ffff, 4'hf, pdts_pkg::RESP_OKAY);
    axi_write(32'h0, 32'h0, 4'he, pdts_pkg::RESP_OKAY);
    axi_write(32'h4, 32'h0, 4'hf, pdts_pkg::RESP_OKAY);
    axi_read(32'h0, 32'h3f, pdts_pkg::RESP_OKAY);
    axi_write(32'h40, 32'h0, 4'hf, pdts_pkg::RESP_SLVERR);
    axi_read(32'h40, 32'h0, pdts_pkg::RESP_SLVERR);
    // Each round picks units and counts, then runs random pwm edges.
    for (int r = 0; r < 10; r++) begin
      s = (r == 0) ? 6'h00 : (r == 1) ? 6'h3f : 6'($urandom);
      @(posedge clk_i);
      dta <= (r == 0) ? 6'h00 : 6'($urandom_range(0, 63));
      dtb <= (r == 0) ? 6'h00 : 6'($urandom_range(1, 62));
      axi_write(32'h0, {26'h0, s}, 4'h1, pdts_pkg::RESP_OKAY);
      msel = s;
      axi_read(32'h0, {26'h0, s}, pdts_pkg::RESP_OKAY);
      repeat (500) begin
        @(posedge clk_i);
        for (int p = 0; p < 3; p++) begin
          if ($urandom_range(0, 59) == 0) pwm[p] <= ~pwm[p];
        end
      end
      repeat (70) @(posedge clk_i);
      axi_read(32'h4, {25'h0, ml, 1'b0, mh}, pdts_pkg::RESP_OKAY);
    end
    give_verdict();
  end
endmodule : pdts_top_tb

bind pdts_top pdts_top_asserts #(.NUM_PAIRS(NUM_PAIRS),
  .ACTIVE_PAIRS(ACTIVE_PAIRS), .CNT_W(CNT_W)) u_chk (.clk_i(clk_i),
  .rst_n_i(rst_n_i), .s_axi_awvalid_i(s_axi_awvalid_i),
  .s_axi_awready_o(s_axi_awready_o), .s_axi_wvalid_i(s_axi_wvalid_i),
  .s_axi_wready_o(s_axi_wready_o), .s_axi_bvalid_o(s_axi_bvalid_o),
  .s_axi_bready_i(s_axi_bready_i), .s_axi_bresp_o(s_axi_bresp_o),
  .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
  .s_axi_araddr_i(s_axi_araddr_i), .s_axi_rvalid_o(s_axi_rvalid_o),
  .s_axi_rdata_o(s_axi_rdata_o), .dt_unit_a_cnt_i(dt_unit_a_cnt_i),
  .dt_unit_b_cnt_i(dt_unit_b_cnt_i), .pwm_i(pwm_i), .pwm_hi_o(pwm_hi_o),
  .pwm_lo_o(pwm_lo_o));
